//--- pnp_cfg_defs.svh
`ifndef PNP_CFG_DEFS_SVH
`define PNP_CFG_DEFS_SVH

`define PNP_NUM_FN         7
`define PNP_CFG_BASE_LO    16'h002E
`define PNP_CFG_BASE_HI    16'h004E
`define PNP_IDX_LDN        8'h07
`define PNP_IDX_GCF1       8'h20
`define PNP_IDX_PINMUX     8'h21
`define PNP_IDX_GCF3       8'h22
`define PNP_IDX_ACT        8'h30
`define PNP_IDX_B0H        8'h60
`define PNP_IDX_B0L        8'h61
`define PNP_IDX_B1H        8'h62
`define PNP_IDX_B1L        8'h63
`define PNP_IDX_IRQ        8'h70
`define PNP_IDX_IRQT       8'h71
`define PNP_IDX_DMA0       8'h74
`define PNP_IDX_DMA1       8'h75
`define PNP_IDX_SPEC       8'hF0
`define PNP_GCF1_SWRST_BIT 1
`define PNP_GCF1_LOCK_BIT  7
`define PNP_ACT_MASK       8'h01
`define PNP_IRQ_MASK       8'h1F
`define PNP_IRQT_MASK      8'h03
`define PNP_DMA_MASK       8'h07
`define PNP_GCF3_MASK      8'h03
`define PNP_IRQT_DFLT      8'h02
`define PNP_DMA_NONE       8'h04
`define PNP_UNIMPL_RD      8'h00
`define PNP_PINMUX_DFLT    8'h00
`define PNP_FN_FLOPPY      0
`define PNP_FN_PARALLEL    1
`define PNP_FN_SERIAL2     2
`define PNP_FN_SERIAL1     3
`define PNP_FN_WAKE        4
`define PNP_FN_KBD         5
`define PNP_FN_GENERIC     6
`define PNP_PAR_EXT_BIT    10
`define PNP_KBD_SEL_BIT    2
`define PNP_LIM_LEGACY     16'h07FF
`define PNP_LIM_PARALLEL   16'h03FF
`define PNP_LIM_FULL       16'hFFFF
// Per-function tables, function 6 first, function 0 last
`define PNP_FN_WIN   {3'd5, 3'd1, 3'd4, 3'd3, 3'd3, 3'd3, 3'd3}
`define PNP_FN_LIM   {16'hFFFF, 16'h07FF, 16'hFFFF, 16'h07FF, 16'h07FF, 16'h03FF, 16'h07FF}
`define PNP_FN_BASE0 {16'h0000, 16'h0060, 16'h0000, 16'h03F8, 16'h02F8, 16'h0378, 16'h03F0}
`define PNP_FN_BASE1 {16'h0000, 16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000}
`define PNP_FN_IRQ   {8'h00, 8'h01, 8'h00, 8'h04, 8'h03, 8'h07, 8'h06}
`define PNP_FN_DMA0  {8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h02}
`define PNP_FN_HASDMA 7'b100_0011
`define PNP_FN_ACT   7'b010_0000
`endif

//--- pnp_cfg_pkg.sv
package pnp_cfg_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } pnp_io_req_t;

    typedef struct packed {
        logic        act;
        logic [15:0] base0;
        logic [15:0] base1;
        logic [7:0]  irq;
        logic [7:0]  irqt;
        logic [7:0]  dma0;
        logic [7:0]  dma1;
        logic [7:0]  spec;
    } pnp_fn_regs_t;

    typedef struct packed {
        logic [3:0] irq_num;
        logic       irq_wake;
        logic [1:0] irq_type;
        logic [2:0] dma0;
        logic [2:0] dma1;
    } pnp_fn_res_t;
endpackage

//--- pnp_cfg.sv
`include "pnp_cfg_defs.svh"

module pnp_cfg (
    input  wire logic                                        clk_in,
    input  wire logic                                        resetn_in,
    input  wire logic                                        hardware_reset_in,
    input  wire logic                                        standby_reset_in,
    input  wire logic                                        base_select_strap_in,
    input  wire pnp_cfg_pkg::pnp_io_req_t                    io_req_in,
    output logic [7:0]                                       io_rdata_out,
    output logic                                             io_cfg_hit_out,
    output logic [`PNP_NUM_FN-1:0]                           fn_hit_out,
    output logic [`PNP_NUM_FN-1:0]                           fn_desc_out,
    output logic [4:0]                                       fn_offset_out,
    output logic [`PNP_NUM_FN-1:0]                           fn_active_out,
    output logic [`PNP_NUM_FN-1:0]                           fn_run_out,
    output pnp_cfg_pkg::pnp_fn_res_t [`PNP_NUM_FN-1:0]       fn_res_out,
    output logic [`PNP_NUM_FN-1:0][7:0]                      fn_spec_out,
    output logic [7:0]                                       pin_mux_out,
    output logic [1:0]                                       pin_ctrl_out
);
    import pnp_cfg_pkg::*;

    localparam int NF = `PNP_NUM_FN;

    logic [2:0]   hw_sync_reg;
    logic [1:0]   sb_sync_reg;
    logic [1:0]   strap_sync_reg;
    logic         hw_rst;
    logic         sb_rst;
    logic         hw_fall;
    logic [1:0]   settle_reg;
    logic         strap_hi_reg;
    logic [15:0]  cfg_base;
    logic [7:0]   index_reg;
    logic [7:0]   ldn_reg;
    logic [7:0]   gcf1_reg;
    logic [7:0]   pinmux_reg;
    logic [7:0]   gcf3_reg;
    logic         sw_rst;
    logic         locked;
    logic         idx_port;
    logic         dat_port;
    logic         dat_wr;
    logic         dat_rd;
    pnp_fn_regs_t fn_reg [NF];
    logic [7:0]   fn_rd [NF];
    logic [NF-1:0] hit0;
    logic [NF-1:0] hit1;
    logic [NF-1:0] hitx;
    logic [15:0]  win_mask [NF];
    logic [7:0]   rdata_next;

    // Pin inputs pass two flip-flops before use
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            hw_sync_reg    <= 3'h0;
            sb_sync_reg    <= 2'h0;
            strap_sync_reg <= 2'h0;
        end
        else
        begin
            hw_sync_reg    <= {hw_sync_reg[1:0], hardware_reset_in};
            sb_sync_reg    <= {sb_sync_reg[0], standby_reset_in};
            strap_sync_reg <= {strap_sync_reg[0], base_select_strap_in};
        end
    end

    assign hw_rst  = hw_sync_reg[1];
    assign hw_fall = hw_sync_reg[2] & ~hw_sync_reg[1];
    assign sb_rst  = sb_sync_reg[1];

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            settle_reg   <= 2'h0;
            strap_hi_reg <= 1'b0;
        end
        else
        begin
            if (settle_reg != 2'h3)
                settle_reg <= settle_reg + 2'h1;
            if (hw_fall || settle_reg == 2'h2)
                strap_hi_reg <= strap_sync_reg[1];
        end
    end

    assign cfg_base = strap_hi_reg ? `PNP_CFG_BASE_HI : `PNP_CFG_BASE_LO;

    assign idx_port = (io_req_in.addr == cfg_base);
    assign dat_port = (io_req_in.addr == cfg_base + 16'h0001);
    assign dat_wr   = dat_port & io_req_in.wr;
    assign dat_rd   = dat_port & io_req_in.rd;
    assign locked   = gcf1_reg[`PNP_GCF1_LOCK_BIT];

    assign sw_rst = gcf1_reg[`PNP_GCF1_SWRST_BIT];

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            index_reg  <= 8'h00;
            ldn_reg    <= 8'h00;
            gcf1_reg   <= 8'h00;
            pinmux_reg <= `PNP_PINMUX_DFLT;
        end
        else if (hw_rst)
        begin
            index_reg  <= 8'h00;
            ldn_reg    <= 8'h00;
            gcf1_reg   <= 8'h00;
            pinmux_reg <= `PNP_PINMUX_DFLT;
        end
        else if (sw_rst)
        begin
            // lock bit and locked pins survive
            ldn_reg  <= 8'h00;
            gcf1_reg <= gcf1_reg & (8'h01 << `PNP_GCF1_LOCK_BIT);
            if (!locked)
                pinmux_reg <= `PNP_PINMUX_DFLT;
        end
        else
        begin
            if (idx_port && io_req_in.wr)
                index_reg <= io_req_in.wdata;
            if (dat_wr && index_reg == `PNP_IDX_LDN)
                ldn_reg <= io_req_in.wdata;
            if (dat_wr && index_reg == `PNP_IDX_GCF1)
                gcf1_reg <= io_req_in.wdata | (gcf1_reg & (8'h01 << `PNP_GCF1_LOCK_BIT));
            if (dat_wr && index_reg == `PNP_IDX_PINMUX && !locked)
                pinmux_reg <= io_req_in.wdata;
        end
    end

    // battery-backed pin control, cleared only by retention power-up
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            gcf3_reg <= 8'h00;
        else if (dat_wr && index_reg == `PNP_IDX_GCF3 && !locked)
            gcf3_reg <= io_req_in.wdata & `PNP_GCF3_MASK;
    end

    assign pin_mux_out  = pinmux_reg;
    assign pin_ctrl_out = gcf3_reg[1:0];

    genvar g;
    generate
        for (g = 0; g < NF; g++)
        begin : gen_fn
            localparam logic [2:0]  WIN  = 3'(`PNP_FN_WIN >> (g * 3));
            localparam logic [15:0] LIM  = 16'(`PNP_FN_LIM >> (g * 16));
            localparam logic [15:0] B0D  = 16'(`PNP_FN_BASE0 >> (g * 16));
            localparam logic [15:0] B1D  = 16'(`PNP_FN_BASE1 >> (g * 16));
            localparam logic [7:0]  IRQD = 8'(`PNP_FN_IRQ >> (g * 8));
            localparam logic [7:0]  DMAD = 8'(`PNP_FN_DMA0 >> (g * 8));
            localparam logic        HASD = 1'(`PNP_FN_HASDMA >> g);
            localparam logic        ACTD = 1'(`PNP_FN_ACT >> g);
            // alignment and range in one mask
            localparam logic [15:0] BMASK = LIM & ~((16'h0001 << WIN) - 16'h0001);
            localparam pnp_fn_regs_t DFLT = '{act: ACTD, base0: B0D, base1: B1D,
                irq: IRQD, irqt: `PNP_IRQT_DFLT, dma0: DMAD, dma1: `PNP_DMA_NONE,
                spec: 8'h00};
            logic sel;
            logic wr;

            assign sel = (ldn_reg == 8'(g));
            assign wr  = dat_wr & sel;

            always_ff @(posedge clk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                    fn_reg[g] <= DFLT;
                else if ((hw_rst && g != `PNP_FN_WAKE) || sw_rst
                         || (sb_rst && g == `PNP_FN_WAKE))
                begin
                    fn_reg[g] <= DFLT;
                    if ((sw_rst && locked) || g == `PNP_FN_WAKE)
                        fn_reg[g].spec <= fn_reg[g].spec;
                end
                else if (wr)
                begin
                    case (index_reg)
                        `PNP_IDX_ACT:  fn_reg[g].act <= io_req_in.wdata[0];
                        `PNP_IDX_B0H:  fn_reg[g].base0[15:8] <= io_req_in.wdata & BMASK[15:8];
                        `PNP_IDX_B0L:  fn_reg[g].base0[7:0] <= io_req_in.wdata & BMASK[7:0];
                        `PNP_IDX_B1H:  fn_reg[g].base1[15:8] <= io_req_in.wdata & BMASK[15:8];
                        `PNP_IDX_B1L:  fn_reg[g].base1[7:0] <= io_req_in.wdata & BMASK[7:0];
                        `PNP_IDX_IRQ:  fn_reg[g].irq <= io_req_in.wdata & `PNP_IRQ_MASK;
                        `PNP_IDX_IRQT: fn_reg[g].irqt <= io_req_in.wdata & `PNP_IRQT_MASK;
                        `PNP_IDX_DMA0: if (HASD) fn_reg[g].dma0 <= io_req_in.wdata & `PNP_DMA_MASK;
                        `PNP_IDX_DMA1: if (HASD) fn_reg[g].dma1 <= io_req_in.wdata & `PNP_DMA_MASK;
                        `PNP_IDX_SPEC: if (!locked) fn_reg[g].spec <= io_req_in.wdata;
                        default:       fn_reg[g].act <= fn_reg[g].act;
                    endcase
                end
            end

            always_comb
            begin
                case (index_reg)
                    `PNP_IDX_ACT:  fn_rd[g] = {7'h00, fn_reg[g].act};
                    `PNP_IDX_B0H:  fn_rd[g] = fn_reg[g].base0[15:8];
                    `PNP_IDX_B0L:  fn_rd[g] = fn_reg[g].base0[7:0];
                    `PNP_IDX_B1H:  fn_rd[g] = fn_reg[g].base1[15:8];
                    `PNP_IDX_B1L:  fn_rd[g] = fn_reg[g].base1[7:0];
                    `PNP_IDX_IRQ:  fn_rd[g] = fn_reg[g].irq;
                    `PNP_IDX_IRQT: fn_rd[g] = fn_reg[g].irqt;
                    `PNP_IDX_DMA0: fn_rd[g] = HASD ? fn_reg[g].dma0 : `PNP_DMA_NONE;
                    `PNP_IDX_DMA1: fn_rd[g] = HASD ? fn_reg[g].dma1 : `PNP_DMA_NONE;
                    `PNP_IDX_SPEC: fn_rd[g] = fn_reg[g].spec;
                    default:       fn_rd[g] = `PNP_UNIMPL_RD;
                endcase
            end

            // window compare over all 16 bits
            assign win_mask[g] = ~((16'h0001 << WIN) - 16'h0001);
            assign hit0[g] = fn_reg[g].act
                             && ((io_req_in.addr & win_mask[g]) == fn_reg[g].base0);
            assign hit1[g] = fn_reg[g].act && (fn_reg[g].base1 != 16'h0000)
                             && ((io_req_in.addr & win_mask[g]) == fn_reg[g].base1);
            // parallel port extended set at bit 10
            if (g == `PNP_FN_PARALLEL)
            begin : gen_ext
                assign hitx[g] = fn_reg[g].act && ((io_req_in.addr & win_mask[g])
                    == (fn_reg[g].base0 | (16'h0001 << `PNP_PAR_EXT_BIT)));
            end
            else
            begin : gen_noext
                assign hitx[g] = 1'b0;
            end

            always_ff @(posedge clk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                begin
                    fn_res_out[g] <= '{irq_num: 4'h0, irq_wake: 1'b0, irq_type: 2'h0,
                                       dma0: 3'h4, dma1: 3'h4};
                end
                else
                begin
                    fn_res_out[g].irq_num  <= fn_reg[g].act ? fn_reg[g].irq[3:0] : 4'h0;
                    fn_res_out[g].irq_wake <= fn_reg[g].act & fn_reg[g].irq[4];
                    fn_res_out[g].irq_type <= fn_reg[g].act ? fn_reg[g].irqt[1:0] : 2'h0;
                    fn_res_out[g].dma0     <= fn_reg[g].act ? fn_reg[g].dma0[2:0] : 3'h4;
                    fn_res_out[g].dma1     <= fn_reg[g].act ? fn_reg[g].dma1[2:0] : 3'h4;
                end
            end

            assign fn_active_out[g] = fn_reg[g].act;
            // wake-up control keeps running while inaccessible
            assign fn_run_out[g]    = fn_reg[g].act | (g == `PNP_FN_WAKE);
            assign fn_spec_out[g]   = fn_reg[g].spec;
        end
    endgenerate

    always_comb
    begin
        rdata_next = `PNP_UNIMPL_RD;
        if (idx_port)
            rdata_next = index_reg;
        else
        begin
            case (index_reg)
                `PNP_IDX_LDN:    rdata_next = ldn_reg;
                `PNP_IDX_GCF1:   rdata_next = gcf1_reg;
                `PNP_IDX_PINMUX: rdata_next = pinmux_reg;
                `PNP_IDX_GCF3:   rdata_next = gcf3_reg;
                `PNP_IDX_DMA0:   rdata_next = `PNP_DMA_NONE;
                `PNP_IDX_DMA1:   rdata_next = `PNP_DMA_NONE;
                default:         rdata_next = `PNP_UNIMPL_RD;
            endcase
            if (ldn_reg < 8'(NF) && index_reg >= `PNP_IDX_ACT)
                rdata_next = fn_rd[ldn_reg[2:0]];
        end
    end

    // Registered read data and decode results, one cycle after the request
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            io_rdata_out   <= 8'h00;
            io_cfg_hit_out <= 1'b0;
            fn_hit_out     <= '0;
            fn_desc_out    <= '0;
            fn_offset_out  <= 5'h00;
        end
        else
        begin
            if ((idx_port || dat_port) && io_req_in.rd)
                io_rdata_out <= rdata_next;
            io_cfg_hit_out <= (idx_port | dat_port) & (io_req_in.rd | io_req_in.wr);
            fn_hit_out     <= (idx_port | dat_port | ~(io_req_in.rd | io_req_in.wr))
                              ? '0 : (hit0 | hit1 | hitx);
            // descriptor is set when the second base or the parallel extended set matched
            fn_desc_out    <= hit1 | hitx;
            fn_offset_out  <= io_req_in.addr[4:0];
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    kbd_only_active_a: assert property (hw_rst |=> fn_active_out == 7'b010_0000)
        else $error("keyboard not sole active function after hardware reset");
    hit_needs_act_a: assert property (fn_hit_out[0] |-> $past(fn_active_out[0]))
        else $error("floppy hit while inactive");
    base_align_a: assert property (fn_reg[`PNP_FN_GENERIC].base0[4:0] == 5'h00)
        else $error("generic base not 32-byte aligned");
    legacy_limit_a: assert property (fn_reg[`PNP_FN_SERIAL1].base0[15:11] == 5'h00)
        else $error("serial base above legacy range");
    par_limit_a: assert property (fn_reg[`PNP_FN_PARALLEL].base0 <= 16'h03F8)
        else $error("parallel base above 3F8h");
    dma_unimpl_a: assert property ((dat_rd && index_reg == `PNP_IDX_DMA0
        && ldn_reg == 8'h02) |=> io_rdata_out == 8'h04)
        else $error("missing DMA select did not read 04h");
    sw_clear_a: assert property (sw_rst |=> fn_reg[`PNP_FN_GENERIC].base0 == 16'h0000
        && fn_reg[0].base0 == 16'h03F0)
        else $error("software reset defaults wrong");
    cfg_base_a: assert property (hw_fall |=> (cfg_base == ($past(strap_sync_reg[1])
        ? 16'h004E : 16'h002E)))
        else $error("config base not 2Eh or 4Eh");
    lock_keep_a: assert property ((sw_rst && locked) |=>
        fn_reg[0].spec == $past(fn_reg[0].spec))
        else $error("locked setting changed by software reset");
    wake_keep_a: assert property ((hw_rst && !sw_rst && !sb_rst) |=>
        fn_reg[`PNP_FN_WAKE] == $past(fn_reg[`PNP_FN_WAKE]))
        else $error("hardware reset touched wake-up control");

    sw_reset_c: cover property (sw_rst);
    fn_hit_c: cover property (fn_hit_out[`PNP_FN_KBD] && fn_desc_out[`PNP_FN_KBD]);
    par_ext_c: cover property (hitx[`PNP_FN_PARALLEL]);
endmodule

//--- pnp_host.sv
module pnp_host (
    input  wire logic                   clk_in,
    input  wire logic [7:0]             rdata_in,
    output pnp_cfg_pkg::pnp_io_req_t    req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import pnp_cfg_pkg::*;

    logic [15:0] base_reg = 16'h002E;

    initial req_out = '0;

    // One I/O cycle: launched at a falling edge, held across one rising edge
    task automatic io_cyc(input logic [15:0] a, input logic w, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge clk_in);
        req_out = '{addr: a, wr: w, rd: !w, wdata: d};
        @(negedge clk_in);
        // Released bus shows inverted leftovers, not the last value
        req_out = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
        q = rdata_in;
    endtask

    task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        io_cyc(base_reg, 1'b1, idx, q);
        io_cyc(base_reg + 16'h0001, 1'b1, d, q);
    endtask

    task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] q);
        io_cyc(base_reg, 1'b1, idx, q);
        io_cyc(base_reg + 16'h0001, 1'b0, 8'h00, q);
    endtask
endmodule

//--- pnp_config_and_address_decode_bench.sv
module pnp_config_and_address_decode_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pnp_cfg_pkg::*;

    logic                    clk_in = 1'b0;
    logic                    resetn_in = 1'b0;
    logic                    hw_rst = 1'b0;
    logic                    strap = 1'b0;
    logic                    sb_rst = 1'b0;
    logic [6:0]              fn_act;
    logic [6:0]              fn_run;
    pnp_io_req_t             req;
    logic [7:0]              rdata;
    logic                    cfg_hit;
    logic [6:0]              fn_hit;
    logic [6:0]              fn_desc;
    logic [4:0]              fn_off;
    pnp_fn_res_t [6:0]       fn_res;
    logic [6:0][7:0]         fn_spec;
    logic [7:0]              pin_mux;
    logic [1:0]              pin_ctrl;
    logic [7:0]              q;
    int                      errors = 0;
    int                      n_tests = 0;
    int                      cycles = 0;

    always #4 clk_in = ~clk_in;

    pnp_cfg DUT (
        .clk_in               (clk_in),
        .resetn_in            (resetn_in),
        .hardware_reset_in    (hw_rst),
        .standby_reset_in     (sb_rst),
        .base_select_strap_in (strap),
        .io_req_in            (req),
        .io_rdata_out         (rdata),
        .io_cfg_hit_out       (cfg_hit),
        .fn_hit_out           (fn_hit),
        .fn_desc_out          (fn_desc),
        .fn_offset_out        (fn_off),
        .fn_active_out        (fn_act),
        .fn_run_out           (fn_run),
        .fn_res_out           (fn_res),
        .fn_spec_out          (fn_spec),
        .pin_mux_out          (pin_mux),
        .pin_ctrl_out         (pin_ctrl)
    );

    pnp_host host (
        .clk_in   (clk_in),
        .rdata_in (rdata),
        .req_out  (req)
    );

    task automatic report_and_stop();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
            errors++;
        end
    endtask

    task automatic cw(input logic [7:0] idx, input logic [7:0] d);
        host.cfg_wr(idx, d);
    endtask

    task automatic cr(input logic [7:0] idx, input logic [7:0] e);
        host.cfg_rd(idx, q);
        chk({8'h00, q}, {8'h00, e});
    endtask

    // Plain read cycle at a function address, then the hit vector
    task automatic acc(input logic [15:0] a, input logic [6:0] e);
        host.io_cyc(a, 1'b0, 8'h00, q);
        chk({9'h000, fn_hit}, {9'h000, e});
    endtask

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            report_and_stop();
        end
    end

    initial
    begin
        repeat (12) @(posedge clk_in);
        @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (5) @(negedge clk_in);
        cw(8'h07, 8'h05);
        cr(8'h30, 8'h01);
        acc(16'h0064, 7'b010_0000);
        chk({11'h000, fn_off}, 16'h0004);
        cw(8'h07, 8'h00);
        cr(8'h30, 8'h00);
        cr(8'h60, 8'h03);
        cr(8'h61, 8'hF0);
        acc(16'h03F2, 7'b000_0000);
        cw(8'h30, 8'h01);
        acc(16'h03F2, 7'b000_0001);
        chk({11'h000, fn_off}, 16'h0012);
        cw(8'h60, 8'hFF);
        cr(8'h60, 8'h07);
        cw(8'h07, 8'h01);
        cw(8'h60, 8'hFF);
        cw(8'h61, 8'hFF);
        cr(8'h60, 8'h03);
        cr(8'h61, 8'hF8);
        cw(8'h07, 8'h06);
        cr(8'h60, 8'h00);
        cw(8'h60, 8'h12);
        cw(8'h61, 8'h3F);
        cr(8'h61, 8'h20);
        cw(8'h30, 8'h01);
        acc(16'h1234, 7'b100_0000);
        acc(16'h0234, 7'b000_0000);
        cw(8'h62, 8'hAB);
        cw(8'h63, 8'hC0);
        cr(8'h63, 8'hC0);
        acc(16'hABC5, 7'b100_0000);
        chk({9'h000, fn_desc}, 16'h0040);
        cw(8'h70, 8'h15);
        cr(8'h70, 8'h15);
        chk({11'h000, fn_res[6].irq_wake, fn_res[6].irq_num}, 16'h0015);
        cw(8'h71, 8'h03);
        cr(8'h71, 8'h03);
        chk({14'h0000, fn_res[6].irq_type}, 16'h0003);
        cw(8'h74, 8'h01);
        cr(8'h74, 8'h01);
        chk({13'h0000, fn_res[6].dma0}, 16'h0001);
        cr(8'h75, 8'h04);
        cr(8'hF3, 8'h00);
        cw(8'hF0, 8'h5A);
        chk({8'h00, fn_spec[6]}, 16'h005A);
        cw(8'h21, 8'h05);
        cw(8'h22, 8'h03);
        cw(8'h20, 8'h80);
        cw(8'h20, 8'h82);
        cw(8'h07, 8'h06);
        cr(8'h30, 8'h00);
        chk({8'h00, pin_mux}, 16'h0005);
        chk({8'h00, fn_spec[6]}, 16'h005A);
        chk({9'h000, fn_res[6].dma0, fn_res[6].irq_num}, 16'h0040);
        cr(8'h61, 8'h00);
        cw(8'h07, 8'h02);
        cw(8'h74, 8'h01);
        cr(8'h74, 8'h04);
        strap = 1'b1;
        hw_rst = 1'b1;
        repeat (2) @(negedge clk_in);
        hw_rst = 1'b0;
        repeat (8) @(negedge clk_in);
        host.base_reg = 16'h004E;
        chk({14'h0000, pin_ctrl}, 16'h0003);
        chk({8'h00, pin_mux}, 16'h0000);
        chk({9'h000, fn_act}, 16'h0020);
        chk({9'h000, fn_run}, 16'h0030);
        cw(8'h07, 8'h05);
        cr(8'h30, 8'h01);
        chk({15'h0000, cfg_hit}, 16'h0001);
        cw(8'h07, 8'h04);
        cw(8'h61, 8'h35);
        cr(8'h61, 8'h30);
        cw(8'hF0, 8'hA5);
        sb_rst = 1'b1;
        repeat (2) @(negedge clk_in);
        sb_rst = 1'b0;
        repeat (4) @(negedge clk_in);
        cr(8'h61, 8'h00);
        chk({8'h00, fn_spec[4]}, 16'h00A5);
        resetn_in = 1'b0;
        repeat (2) @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (5) @(negedge clk_in);
        chk({14'h0000, pin_ctrl}, 16'h0000);
        chk({8'h00, fn_spec[4]}, 16'h0000);
        cr(8'h30, 8'h00);
        report_and_stop();
    end
endmodule
